/* File: src/fhbfe_device.sv */
// fhbfe_device: device end of the flash bus front end
// assumes: host end on the other modport; all pins synchronous to clk_i;
// the command interpreter and array sit behind the user-side ports
`include "fhbfe_regs.svh"

module fhbfe_device
  import fhbfe_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'ha5   // arbitrary value
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // pins to the host
  fhbfe_if.dev             bus,
  // interface select strap and engine state
  input  wire logic        iface_pp_i,
  input  wire logic        busy_i,
  // programmer read source and signature mode
  input  wire logic [7:0]  rd_data_i,
  input  wire logic        sig_sel_i,
  // serial-bus write towards the command interpreter
  output logic             wr_valid_o,
  output logic      [31:0] wr_addr_o,
  output logic      [7:0]  wr_data_o,
  output logic             wr_array_o,
  // programmer-port write towards the command interpreter
  output logic             pp_wr_valid_o,
  output logic      [21:0] pp_addr_o,
  output logic      [7:0]  pp_wr_data_o,
  // status towards the engine
  output logic             abort_o,
  output logic             unprot_o,
  output logic             sel_o
);
  // state and datapath flops, their next values and strobes
  fhbfe_lpc_st_t st_r;       // serial bus state
  fhbfe_lpc_st_t st_nxt;     // next serial bus state
  logic [2:0]    cnt_r;      // address nibble counter
  logic [2:0]    cnt_nxt;    // next address nibble count
  logic [31:0]   addr_r;     // address being assembled
  logic [3:0]    dlo_r;      // low data nibble
  logic [3:0]    lad_r;      // nibble driven out
  logic [3:0]    lad_nxt;    // next nibble driven out
  logic          drv_r;      // device owns nibble lines
  logic          drv_nxt;    // next ownership
  logic          take_lo;    // capture low nibble
  logic          take_hi;    // capture high nibble and issue
  logic          shift_en;   // shift address nibble in
  logic          irst_q_r;   // previous interface reset
  logic          pp_valid;   // programmer write from port
  logic [7:0]    pp_data;    // programmer write data from port
  logic [7:0]    pp_dq;      // programmer read data
  logic          pp_dq_oe;   // programmer read enable
  // decode of the pins
  wire        irst_ok   = bus.interface_reset_n;
  wire        lpc_on    = !iface_pp_i && irst_ok;
  wire        pp_on     = iface_pp_i && irst_ok;
  wire        frame     = !bus.lframe_n;
  wire [3:0]  nib       = bus.lad;
  wire        start_hit = frame && (nib == `FHBFE_START_NIB);
  wire        ctype_ok  = (nib[3:2] == `FHBFE_CTYPE_TOP) &&
                          nib[`FHBFE_CTYPE_DIR_BIT];
  wire        addr_ok   = &addr_r[31:`FHBFE_FIXED_LSB];
  wire        last_addr = (cnt_r == `FHBFE_ADDR_NIBS);
  // serial bus sequencing and nibble drive plan
  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    lad_nxt  = `FHBFE_TAR_NIB;
    drv_nxt  = 1'b0;
    take_lo  = 1'b0;
    take_hi  = 1'b0;
    shift_en = 1'b0;
    if (!lpc_on)
    begin
      // reset or other interface: idle and floating
      st_nxt = FHBFE_S_IDLE;
    end
    else if (frame)
    begin
      // frame low: a start, or an abort of the running cycle
      st_nxt  = start_hit ? FHBFE_S_CTYPE : FHBFE_S_IDLE;
      cnt_nxt = 3'h0;
    end
    else
    begin
      unique case (st_r)
        // wait for the next start
        FHBFE_S_IDLE:  st_nxt = FHBFE_S_IDLE;
        // only a write type goes on, bit0 unused
        FHBFE_S_CTYPE: st_nxt = ctype_ok ? FHBFE_S_ADDR : FHBFE_S_IDLE;
        FHBFE_S_ADDR:
        begin
          // one nibble per clock, top nibble first
          shift_en = 1'b1;
          cnt_nxt  = cnt_r + 3'h1;
          if (last_addr)
            st_nxt = FHBFE_S_DLO;
        end
        FHBFE_S_DLO:
        begin
          // wrong fixed bits drop the cycle silently
          take_lo = 1'b1;
          st_nxt  = addr_ok ? FHBFE_S_DHI : FHBFE_S_IDLE;
        end
        FHBFE_S_DHI:
        begin
          // host turnaround follows, lines still host owned
          take_hi = 1'b1;
          st_nxt  = FHBFE_S_TAR_H;
        end
        FHBFE_S_TAR_H:
        begin
          // take the lines for the second turnaround
          drv_nxt = 1'b1;
          st_nxt  = FHBFE_S_TAR_D;
        end
        FHBFE_S_TAR_D:
        begin
          // ready sync at once, no wait nibbles
          drv_nxt = 1'b1;
          lad_nxt = `FHBFE_SYNC_NIB;
          st_nxt  = FHBFE_S_SYNC;
        end
        FHBFE_S_SYNC:
        begin
          // own turnaround driven high
          drv_nxt = 1'b1;
          lad_nxt = `FHBFE_TAR_NIB;
          st_nxt  = FHBFE_S_TAR_O;
        end
        // release in the last clock, drive defaults off
        FHBFE_S_TAR_O: st_nxt = FHBFE_S_IDLE;
        // illegal code recovers to idle
        default:       st_nxt = FHBFE_S_IDLE;
      endcase
    end
  end

  // serial bus state, counter and nibble drive
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r  <= FHBFE_S_IDLE;
      cnt_r <= 3'h0;
      lad_r <= `FHBFE_TAR_NIB;
      drv_r <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      lad_r <= lad_nxt;
      drv_r <= drv_nxt;
    end
  end
  // address assembly and data capture
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      addr_r <= 32'h0;
      dlo_r  <= 4'h0;
    end
    else
    begin
      if (shift_en)
        addr_r <= {addr_r[27:0], nib};
      if (take_lo)
        dlo_r <= nib;
    end
  end
  // command issue as soon as the high nibble is in
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_valid_o <= 1'b0;
      wr_addr_o  <= 32'h0;
      wr_data_o  <= 8'h0;
      wr_array_o <= 1'b0;
    end
    else
    begin
      wr_valid_o <= take_hi && lpc_on && !frame;
      if (take_hi)
      begin
        wr_addr_o  <= addr_r;
        wr_data_o  <= {nib, dlo_r};
        wr_array_o <= addr_r[`FHBFE_TARGET_BIT];
      end
    end
  end
  // reset edge aborts a running program or erase at once
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irst_q_r <= 1'b1;
      abort_o  <= 1'b0;
    end
    else
    begin
      irst_q_r <= irst_ok;
      abort_o  <= irst_q_r && !irst_ok && busy_i;
    end
  end

  // programmer port: address halves, strobe capture, read drive
  fhbfe_pp_port #(
    .MFR_CODE (MFR_CODE),
    .DEV_CODE (DEV_CODE)
  ) u_pp (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .active_i   (pp_on),
    .row_col_i  (bus.row_col_select),
    .maddr_i    (bus.mux_address_pins),
    .oe_n_i     (bus.oe_n),
    .we_n_i     (bus.we_n),
    .dq_i       (bus.parallel_data_pins),
    .dq_o       (pp_dq),
    .dq_oe_o    (pp_dq_oe),
    .sig_sel_i  (sig_sel_i),
    .rd_data_i  (rd_data_i),
    .addr_o     (pp_addr_o),
    .wr_valid_o (pp_valid),
    .wr_data_o  (pp_data)
  );

  // programmer writes reach only the command interpreter
  assign pp_wr_valid_o = pp_valid && pp_on;
  assign pp_wr_data_o  = pp_data;

  // pin drive, floating under reset or when not selected
  assign bus.lad_d    = lad_r;
  assign bus.lad_d_oe = drv_r && lpc_on;
  assign bus.dq_d     = pp_dq;
  assign bus.dq_d_oe  = pp_dq_oe;

  // protection off on the programmer port, selection flag
  assign unprot_o = iface_pp_i;
  assign sel_o    = irst_ok;
endmodule // fhbfe_device

/* File: shared/fhbfe_regs.svh */
// fhbfe_regs.svh: constants of the flash host bus front end
// assumes: included by bare name; definitions only
`ifndef FHBFE_REGS_SVH
`define FHBFE_REGS_SVH

// serial nibble bus codes
`define FHBFE_START_NIB     4'h0
`define FHBFE_CTYPE_WR_NIB  4'h6
`define FHBFE_CTYPE_TOP     2'h1
`define FHBFE_CTYPE_DIR_BIT 1
`define FHBFE_TAR_NIB       4'hf
`define FHBFE_SYNC_NIB      4'h0
`define FHBFE_ADDR_NIBS     3'h7
`define FHBFE_FIXED_LSB     23
`define FHBFE_TARGET_BIT    22

// host cycle indices of a serial write (cycle number minus one)
`define FHBFE_IDX_DLO       5'h0a
`define FHBFE_IDX_DHI       5'h0b
`define FHBFE_IDX_TAR_H     5'h0c
`define FHBFE_IDX_SYNC      5'h0e
`define FHBFE_IDX_LAST      5'h10

// timing
`define FHBFE_CLK_PERIOD_NS     10
`define FHBFE_RESET_PULSE_MIN_NS 100
`define FHBFE_RESET_PULSE_MIN_CYC \
  ((`FHBFE_RESET_PULSE_MIN_NS + `FHBFE_CLK_PERIOD_NS - 1) / `FHBFE_CLK_PERIOD_NS)
`define FHBFE_RESET_ABORT_TIME_NS 100

`endif

/* File: shared/fhbfe_pkg.sv */
// fhbfe_pkg: types shared by both ends
// assumes: constants come from fhbfe_regs.svh
package fhbfe_pkg;

  // device serial-bus state, gray along the write path
  typedef enum logic [3:0] {
    FHBFE_S_IDLE  = 4'h0,
    FHBFE_S_CTYPE = 4'h1,
    FHBFE_S_ADDR  = 4'h3,
    FHBFE_S_DLO   = 4'h2,
    FHBFE_S_DHI   = 4'h6,
    FHBFE_S_TAR_H = 4'h7,
    FHBFE_S_TAR_D = 4'h5,
    FHBFE_S_SYNC  = 4'h4,
    FHBFE_S_TAR_O = 4'hc
  } fhbfe_lpc_st_t;

endpackage

/* File: shared/fhbfe_if.sv */
// fhbfe_if: serial nibble bus and programmer port between host and device
// assumes: testbench instantiates it; shared pins resolve here from enables
interface fhbfe_if;
  // serial nibble bus
  logic       lframe_n;   // frame, low active, host driven
  logic [3:0] lad_h;      // host nibble out
  logic       lad_h_oe;   // host drives nibble
  logic [3:0] lad_d;      // device nibble out
  logic       lad_d_oe;   // device drives nibble
  logic [3:0] lad;        // resolved nibble, pulled high
  // programmer port
  logic        row_col_select;     // fall latches row, rise latches column
  logic [10:0] mux_address_pins;   // shared row/column address
  logic        oe_n;               // output enable, low active
  logic        we_n;               // write strobe, low active
  logic        interface_reset_n;  // interface reset, low active
  logic [7:0]  dq_h;               // host data out
  logic        dq_h_oe;            // host drives data
  logic [7:0]  dq_d;               // device data out
  logic        dq_d_oe;            // device drives data
  logic [7:0]  parallel_data_pins; // resolved data, pulled high

  assign lad = lad_d_oe ? lad_d : (lad_h_oe ? lad_h : 4'hf);
  assign parallel_data_pins = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'hff);

  modport host (
    output lframe_n, lad_h, lad_h_oe, row_col_select, mux_address_pins,
    output oe_n, we_n, interface_reset_n, dq_h, dq_h_oe,
    input  lad, parallel_data_pins
  );
  modport dev (
    input  lframe_n, lad, row_col_select, mux_address_pins,
    input  oe_n, we_n, interface_reset_n, parallel_data_pins,
    output lad_d, lad_d_oe, dq_d, dq_d_oe
  );
endinterface

/* File: src/fhbfe_pp_port.sv */
// fhbfe_pp_port: programmer-port address latch, write capture, read drive
// assumes: pins synchronous to clk_i; active_i low floats and idles the port
module fhbfe_pp_port
  import fhbfe_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'ha5   // arbitrary value
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // port pins
  input  wire logic        active_i,
  input  wire logic        row_col_i,
  input  wire logic [10:0] maddr_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic             dq_oe_o,
  // user side
  input  wire logic        sig_sel_i,
  input  wire logic [7:0]  rd_data_i,
  output logic      [21:0] addr_o,
  output logic             wr_valid_o,
  output logic      [7:0]  wr_data_o
);
  logic        row_col_q_r; // previous row/column select
  logic        we_q_r;      // previous write strobe
  logic [7:0]  hold_r;      // data seen while strobe low
  wire         row_fall = active_i && row_col_q_r && !row_col_i;
  wire         col_rise = active_i && !row_col_q_r && row_col_i;
  wire         we_rise = active_i && !we_q_r && we_n_i && oe_n_i;
  wire         sig_hit = sig_sel_i && (addr_o[18:1] == 18'h0);
  wire [7:0]   rd_mux  = sig_hit ? (addr_o[0] ? DEV_CODE : MFR_CODE) : rd_data_i;

  // read drive only with strobe and reset high, enable low
  assign dq_oe_o = active_i && !oe_n_i && we_n_i;

  // edge history and address halves
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      row_col_q_r <= 1'b1;
      we_q_r      <= 1'b1;
      addr_o <= 22'h0;
    end
    else
    begin
      row_col_q_r <= row_col_i;
      we_q_r      <= we_n_i;
      if (row_fall)
        addr_o[10:0] <= maddr_i;
      if (col_rise)
        addr_o[21:11] <= maddr_i;
    end
  end

  // capture on strobe rise, read data from flops
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_r     <= 8'h0;
      wr_valid_o <= 1'b0;
      wr_data_o  <= 8'h0;
      dq_o       <= 8'h0;
    end
    else
    begin
      if (!we_n_i)
        hold_r <= dq_i;
      wr_valid_o <= we_rise;
      if (we_rise)
        wr_data_o <= hold_r;
      dq_o <= rd_mux;
    end
  end
endmodule // fhbfe_pp_port

/* File: src/fhbfe_host.sv */
// fhbfe_host: host end issuing serial writes and programmer-port cycles
// assumes: device end on the other modport; one request kind at a time
`include "fhbfe_regs.svh"

module fhbfe_host
  import fhbfe_pkg::*;
#(
  parameter int RST_CYC = `FHBFE_RESET_PULSE_MIN_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // pins to the device
  fhbfe_if.host            bus,
  // serial write request
  input  wire logic        lpc_req_i,
  input  wire logic [31:0] lpc_addr_i,
  input  wire logic [7:0]  lpc_data_i,
  output logic             lpc_busy_o,
  output logic             lpc_done_o,
  output logic             lpc_err_o,
  // programmer-port request
  input  wire logic        pp_req_i,
  input  wire logic        pp_write_i,
  input  wire logic [21:0] pp_addr_i,
  input  wire logic [7:0]  pp_data_i,
  output logic             pp_busy_o,
  output logic             pp_done_o,
  output logic      [7:0]  pp_rd_data_o,
  // interface reset request
  input  wire logic        pp_reset_i
);
  logic [4:0]  idx_r;    // serial cycle index
  logic [31:0] sh_r;     // address nibbles left to send
  logic [7:0]  dat_r;    // data byte to send
  logic [2:0]  stp_r;    // programmer step
  logic        wr_r;     // programmer cycle is a write
  logic [21:0] pa_r;     // programmer address
  logic [7:0]  pd_r;     // programmer write data
  logic [7:0]  rcnt_r;   // reset hold counter
  wire  [4:0]  idx_n  = idx_r + 5'h1;
  wire         go_lpc = lpc_req_i && !lpc_busy_o && !pp_busy_o;
  wire         go_pp  = pp_req_i && !pp_busy_o && !lpc_busy_o;

  // serial write: one nibble per cycle, index by index
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      idx_r <= 5'h0; sh_r <= 32'h0; dat_r <= 8'h0;
      lpc_busy_o <= 1'b0; lpc_done_o <= 1'b0; lpc_err_o <= 1'b0;
      bus.lframe_n <= 1'b1; bus.lad_h <= 4'hf; bus.lad_h_oe <= 1'b0;
    end
    else
    begin
      lpc_done_o <= 1'b0;
      lpc_err_o  <= 1'b0;
      if (go_lpc)
      begin
        // start nibble with frame low
        lpc_busy_o <= 1'b1; idx_r <= 5'h0; sh_r <= lpc_addr_i; dat_r <= lpc_data_i;
        bus.lframe_n <= 1'b0; bus.lad_h <= `FHBFE_START_NIB; bus.lad_h_oe <= 1'b1;
      end
      else if (lpc_busy_o)
      begin
        idx_r <= idx_n;
        bus.lframe_n <= 1'b1;
        if (idx_n == 5'h1)
          bus.lad_h <= `FHBFE_CTYPE_WR_NIB;
        else if (idx_n < `FHBFE_IDX_DLO)
        begin
          bus.lad_h <= sh_r[31:28];
          sh_r <= {sh_r[27:0], 4'h0};
        end
        else if (idx_n == `FHBFE_IDX_DLO)
          bus.lad_h <= dat_r[3:0];
        else if (idx_n == `FHBFE_IDX_DHI)
          bus.lad_h <= dat_r[7:4];
        else
          bus.lad_h <= `FHBFE_TAR_NIB;
        // host lets go after its turnaround, takes the lines back in the last clock
        bus.lad_h_oe <= (idx_n <= `FHBFE_IDX_TAR_H) || (idx_n >= `FHBFE_IDX_LAST);
        if (idx_r == `FHBFE_IDX_SYNC)
        begin
          lpc_done_o <= (bus.lad == `FHBFE_SYNC_NIB);
          lpc_err_o  <= (bus.lad != `FHBFE_SYNC_NIB);
        end
        if (idx_r == `FHBFE_IDX_LAST)
          lpc_busy_o <= 1'b0;
      end
    end
  end

  // programmer port: row, column, then strobe or enable
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stp_r <= 3'h0; wr_r <= 1'b0; pa_r <= 22'h0; pd_r <= 8'h0;
      pp_busy_o <= 1'b0; pp_done_o <= 1'b0; pp_rd_data_o <= 8'h0;
      bus.row_col_select <= 1'b1; bus.mux_address_pins <= 11'h0;
      bus.oe_n <= 1'b1; bus.we_n <= 1'b1; bus.dq_h <= 8'h0; bus.dq_h_oe <= 1'b0;
    end
    else
    begin
      pp_done_o <= 1'b0;
      if (go_pp)
      begin
        pp_busy_o <= 1'b1; stp_r <= 3'h0; wr_r <= pp_write_i;
        pa_r <= pp_addr_i; pd_r <= pp_data_i;
        bus.mux_address_pins <= pp_addr_i[10:0];
      end
      else if (pp_busy_o)
      begin
        stp_r <= stp_r + 3'h1;
        unique case (stp_r)
          3'h0: bus.row_col_select <= 1'b0;
          3'h1: bus.mux_address_pins <= pa_r[21:11];
          3'h2: bus.row_col_select <= 1'b1;
          3'h3:
          begin
            bus.dq_h <= pd_r; bus.dq_h_oe <= wr_r;
            bus.we_n <= !wr_r; bus.oe_n <= wr_r;
          end
          3'h4: bus.we_n <= !wr_r;
          3'h5:
          begin
            if (!wr_r)
              pp_rd_data_o <= bus.parallel_data_pins;
            bus.we_n <= 1'b1; bus.oe_n <= 1'b1;
          end
          3'h6: bus.dq_h_oe <= 1'b0;
          3'h7:
          begin
            pp_busy_o <= 1'b0; pp_done_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // interface reset held for at least the minimum pulse
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rcnt_r <= 8'h0; bus.interface_reset_n <= 1'b1;
    end
    else
    begin
      if (pp_reset_i)
        rcnt_r <= 8'(RST_CYC);
      else if (rcnt_r != 8'h0)
        rcnt_r <= rcnt_r - 8'h1;
      bus.interface_reset_n <= !(pp_reset_i || (rcnt_r > 8'h1));
    end
  end
endmodule // fhbfe_host

/* File: dv/fhbfe_monitor.sv */
// fhbfe_monitor: checks on the shared pins between host and device ends
// assumes: instantiated by the test top beside fhbfe_if
module fhbfe_monitor (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // serial nibble bus
  input wire logic       lframe_n,
  input wire logic [3:0] lad,
  input wire logic [3:0] lad_d,
  input wire logic       lad_d_oe,
  // programmer port
  input wire logic       oe_n,
  input wire logic       we_n,
  input wire logic       interface_reset_n,
  input wire logic       dq_d_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // device nibbles of the closing phase
  sequence s_tar_d; lad_d_oe && lad_d == 4'hf; endsequence
  sequence s_sync; lad_d_oe && lad_d == 4'h0; endsequence
  property p_take; $rose(lad_d_oe) |-> s_tar_d; endproperty
  property p_sync; $rose(lad_d_oe) |=> s_sync; endproperty
  property p_float; $rose(lad_d_oe) |-> ##2 s_tar_d ##1 !lad_d_oe; endproperty
  // header nibbles seen before the device answers
  property p_type; $rose(lad_d_oe) |-> !$past(lframe_n, 13) && $past(lad, 13) == 4'h0
    && $past(lad, 12) ==? 4'b011?; endproperty
  property p_addr; $rose(lad_d_oe) |-> $past(lad, 11) == 4'hf && $past(lad, 10) == 4'hf
    && $past(lad, 9) ==? 4'b1???; endproperty
  property p_host_tar; $rose(lad_d_oe) |-> $past(lad, 1) == 4'hf; endproperty
  // programmer data pins, and no pin drive under interface reset
  property p_oe_off; oe_n |-> !dq_d_oe; endproperty
  property p_rd; dq_d_oe |-> !oe_n && we_n && interface_reset_n; endproperty
  property p_rst; !interface_reset_n ##1 !interface_reset_n |-> !lad_d_oe && !dq_d_oe; endproperty
  a_take: assert property (p_take) else $error("device missed takeover");
  a_sync: assert property (p_sync) else $error("sync nibble wrong");
  a_float: assert property (p_float) else $error("closing turnaround wrong");
  a_type: assert property (p_type) else $error("answered bad start or type");
  a_addr: assert property (p_addr) else $error("answered bad upper address");
  a_host_tar: assert property (p_host_tar) else $error("host turnaround wrong");
  a_oe_off: assert property (p_oe_off) else $error("data driven with oe high");
  a_rd: assert property (p_rd) else $error("data driven outside read");
  a_rst: assert property (p_rst) else $error("driving in reset");
endmodule // fhbfe_monitor

/* File: dv/flash_host_bus_front_end_test.sv */
// flash_host_bus_front_end_test: host and device ends back to back
// assumes: both ends joined through fhbfe_if, monitor beside it
module flash_host_bus_front_end_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MFR = 8'h3e; // arbitrary value
  localparam logic [7:0] DEV = 8'hc1; // arbitrary value
  logic clk_i = 1'b0, rstn_i = 1'b0, lreq = 1'b0, preq = 1'b0, pwr = 1'b0, prst = 1'b0;
  logic iface_pp = 1'b0, busy = 1'b0, sig_sel = 1'b0;
  logic [31:0] laddr = 32'h0, waddr;
  logic [21:0] paddr = 22'h0, paddr_o;
  logic [7:0] ldata = 8'h0, pdata = 8'h0, rd_data = 8'h0, prd, wdata, pwdata;
  logic lbusy, ldone, lerr, pbusy, pdone, wv, warr, pwv, abort, unprot, sel;
  int n_fail = 0, comparisons = 0, cyc = 0, n_wv = 0, n_pwv = 0, n_ab = 0, n_ld = 0, n_le = 0, n_pd = 0;
  fhbfe_if bus_if ();
  fhbfe_host fhbfe_host_i (.clk_i(clk_i), .rstn_i(rstn_i), .bus(bus_if.host),
    .lpc_req_i(lreq), .lpc_addr_i(laddr), .lpc_data_i(ldata), .lpc_busy_o(lbusy), .lpc_done_o(ldone),
    .lpc_err_o(lerr), .pp_req_i(preq), .pp_write_i(pwr), .pp_addr_i(paddr), .pp_data_i(pdata),
    .pp_busy_o(pbusy), .pp_done_o(pdone), .pp_rd_data_o(prd), .pp_reset_i(prst));
  fhbfe_device #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fhbfe_device_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .bus(bus_if.dev), .iface_pp_i(iface_pp), .busy_i(busy), .rd_data_i(rd_data), .sig_sel_i(sig_sel),
    .wr_valid_o(wv), .wr_addr_o(waddr), .wr_data_o(wdata), .wr_array_o(warr), .pp_wr_valid_o(pwv),
    .pp_addr_o(paddr_o), .pp_wr_data_o(pwdata), .abort_o(abort), .unprot_o(unprot), .sel_o(sel));
  fhbfe_monitor fhbfe_monitor_i (.clk_i(clk_i), .rstn_i(rstn_i), .lframe_n(bus_if.lframe_n),
    .lad(bus_if.lad), .lad_d(bus_if.lad_d), .lad_d_oe(bus_if.lad_d_oe), .oe_n(bus_if.oe_n),
    .we_n(bus_if.we_n), .interface_reset_n(bus_if.interface_reset_n), .dq_d_oe(bus_if.dq_d_oe));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // pulse counters and hang guard
  always @(posedge clk_i)
  begin
    n_wv += wv; n_pwv += pwv; n_ab += abort; n_ld += ldone; n_le += lerr; n_pd += pdone;
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // serial write: one-cycle request, then wait for busy to drop
  task automatic lpc_wr(logic [31:0] a, logic [7:0] d);
    laddr = a;
    ldata = d;
    lreq = 1'b1;
    @(posedge clk_i) #1 lreq = 1'b0;
    for (int i = 0; i < 40 && lbusy === 1'b1; i++) @(posedge clk_i) #1;
  endtask
  // programmer-port cycle, read or write
  task automatic pp_op(logic w, logic [21:0] a, logic [7:0] d);
    pwr = w;
    paddr = a;
    pdata = d;
    preq = 1'b1;
    @(posedge clk_i) #1 preq = 1'b0;
    for (int i = 0; i < 40 && pbusy === 1'b1; i++) @(posedge clk_i) #1;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    chk("unprot", 32'h0, unprot);
    lpc_wr(32'hffc0_1234, 8'h3c);
    chk("wr_addr", 32'hffc0_1234, waddr);
    chk("wr_data", 32'h3c, wdata);
    chk("wr_array", 32'h1, warr);
    lpc_wr(32'hff80_0010, 8'ha5);
    chk("wr_array", 32'h0, warr);
    chk("writes", 32'h2, n_wv);
    chk("sync_seen", 32'h2, n_ld);
    lpc_wr(32'h7fc0_0000, 8'h11);
    chk("writes", 32'h2, n_wv);
    chk("no_sync", 32'h1, n_le);
    iface_pp = 1'b1;
    pp_op(1'b1, 22'h2b_1c3d, 8'h96);
    chk("pp_addr", 32'h2b_1c3d, paddr_o);
    chk("pp_data", 32'h96, pwdata);
    chk("pp_writes", 32'h1, n_pwv);
    chk("unprot", 32'h1, unprot);
    rd_data = 8'h4d;
    pp_op(1'b0, 22'h01_2345, 8'h00);
    chk("pp_read", 32'h4d, prd);
    sig_sel = 1'b1;
    pp_op(1'b0, 22'h0, 8'h00);
    chk("mfr_code", MFR, prd);
    pp_op(1'b0, 22'h1, 8'h00);
    chk("dev_code", DEV, prd);
    busy = 1'b1;
    prst = 1'b1;
    @(posedge clk_i) #1 prst = 1'b0;
    @(posedge clk_i) #1;
    chk("selected", 32'h0, sel);
    repeat (6) @(posedge clk_i);
    chk("aborts", 32'h1, n_ab);
    chk("selected", 32'h0, sel);
    repeat (4) @(posedge clk_i);
    chk("selected", 32'h1, sel);
    chk("pp_done", 32'h4, n_pd);
    report_and_stop();
  end
endmodule // flash_host_bus_front_end_test
